// File: cascade_serial_port_pkg.sv
package cascade_serial_port_pkg;

    // Bits in one serial byte and the index of its final bit.
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] FIRST_BIT = 3'h0;

    // Depth of the input synchroniser on every pin.
    localparam int SYNC_STAGES = 3;

    // Width of the reply length counter.
    localparam int LEN_W = 8;
    localparam logic [LEN_W-1:0] LEN_ZERO = 8'h00;
    localparam logic [LEN_W-1:0] LEN_ONE = 8'h01;

    // Depth of the reply data buffer.
    localparam int TX_DEPTH = 4;

    // Reset values of the pin facing registers.
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [4:0] PINS_RESET = 5'h1b;

    // Transfer sequencer, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_CMD = 5'b0_0010,
        ST_WAIT = 5'b0_0100,
        ST_XFER = 5'b0_1000,
        ST_DONE = 5'b1_0000
    } seq_state_t;

    // Pins that arrive from outside the mclk domain.
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
        logic token_n;
        logic rdy_in_n;
    } pin_bundle_t;

    // A received byte with its one-cycle strobe.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_evt_t;

endpackage

// File: reply_fifo.sv
module reply_fifo
    import cascade_serial_port_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = TX_DEPTH
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    // An extra pointer bit tells full from empty without a counter.
    assign in_ready = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage is written only on an accepted word.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // Pointer update.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    // Pushing into a full buffer is refused by in_ready.
    AST_NO_OVERRUN: assert property (@(posedge mclk) disable iff (rst)
        push |=> (wr_ptr_reg - rd_ptr_reg) <= (AW+1)'(DEPTH))
        else $error("Reply buffer holds more words than its depth.");

endmodule

// File: cascade_serial_port.sv
// Behaviour
// - Sample serial input on clock falling edges.
// - Update serial output on clock rising edges.
// - Token low at byte end starts transfer.
// - After transfer, tri-state output, ignore input.
// - Sample token input on clock rising edge.
// - Drop token output in last bit.
// - Token output falls only after rising edge.
// - Select fall with token low enables pins.
// - Select high: no input, output tri-stated.
// - Token fall under select enables output driver.
// - Release output after the commanded byte count.
// - Fault pin open-drain low on input fault.
// - Overflow pin low on overrange or fault.
// - Clock output buffered when enabled, else off.
// - Ready chain output low on new result.
module cascade_serial_port
    import cascade_serial_port_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int DEPTH = TX_DEPTH
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Serial link pins.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // Cascade chain pins.
    input wire logic chain_token_in,
    output logic chain_token_out,
    input wire logic ready_chain_in,
    output logic ready_chain_out,
    // Status pins, open drain.
    output logic fault_n_o,
    output logic fault_n_oe,
    output logic range_exceed_flag_n_o,
    output logic range_exceed_flag_n_oe,
    // Oscillator pins.
    input wire logic crystal_in,
    input wire logic crystal_present,
    input wire logic crystal_enable_bit,
    output logic buffered_osc_out,
    output logic buffered_osc_out_oe,
    // Converter side status.
    input wire logic [CHANNELS-1:0] chan_fault,
    input wire logic [CHANNELS-1:0] chan_overrange,
    input wire logic new_result,
    // Reply bytes from the converter side.
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // Command decoding from the converter side.
    input wire logic [LEN_W-1:0] reply_len,
    // Received command and data bytes.
    output byte_evt_t cmd_out,
    output byte_evt_t rx_out
);

    // Keeps bits where both late stages agree and holds the rest.
    function automatic pin_bundle_t agree_update(pin_bundle_t mid, pin_bundle_t late,
                                                 pin_bundle_t held);
        pin_bundle_t diff;
        diff = mid ^ late;
        return (mid & ~diff) | (held & diff);
    endfunction

    pin_bundle_t pins;
    pin_bundle_t sync1_reg;
    pin_bundle_t sync2_reg;
    pin_bundle_t sync3_reg;
    pin_bundle_t filt_reg;
    pin_bundle_t filt_next;
    logic [2:0] osc_sync_reg;
    seq_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic boundary_reg;
    logic [LEN_W-1:0] len_reg;
    logic [LEN_W-1:0] bytes_left_reg;
    logic [7:0] shift_in_reg;
    logic [7:0] shift_out_reg;
    logic dout_reg;
    logic dout_oe_reg;
    logic token_out_reg;
    logic ready_out_reg;
    logic fault_oe_reg;
    logic over_oe_reg;
    logic osc_out_reg;
    logic osc_oe_reg;
    byte_evt_t cmd_reg;
    byte_evt_t rx_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_idle;
    logic token_fall;
    logic listening;
    logic start_xfer;
    logic load_byte;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic [7:0] next_byte;

    // All pins cross into mclk through three flops; a level counts once
    // the second and third flops agree, which also filters single glitches.
    assign pins = '{sclk: sclk, cs_n: cs_n, din: din, token_n: chain_token_in,
                    rdy_in_n: ready_chain_in};
    assign filt_next = agree_update(sync2_reg, sync3_reg, filt_reg);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_reg <= PINS_RESET;
            sync2_reg <= PINS_RESET;
            sync3_reg <= PINS_RESET;
            filt_reg <= PINS_RESET;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg <= filt_next;
        end
    end

    // Edge events of the filtered pins.
    assign sclk_rise = filt_next.sclk && !filt_reg.sclk;
    assign sclk_fall = !filt_next.sclk && filt_reg.sclk;
    assign cs_fall = !filt_next.cs_n && filt_reg.cs_n;
    assign cs_idle = filt_next.cs_n;
    assign token_fall = !filt_next.token_n && filt_reg.token_n;
    assign listening = (state_reg == ST_CMD) || (state_reg == ST_XFER);

    // A transfer opens at the rising edge that starts a new byte while the
    // token is low; the token is taken only at that rising edge.
    assign start_xfer = sclk_rise && boundary_reg && !filt_next.token_n
                        && (state_reg == ST_WAIT);
    // The opening byte is judged on len_reg, since bytes_left_reg is loaded in the same cycle.
    assign load_byte = sclk_rise && boundary_reg
                       && (((state_reg == ST_XFER) && (bytes_left_reg != LEN_ZERO))
                           || (start_xfer && len_reg != LEN_ZERO));
    // An empty buffer sends zeros rather than stalling the host's clock.
    assign next_byte = fifo_valid ? fifo_data : BYTE_RESET;

    reply_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) u_reply_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(fifo_valid),
        .out_ready(load_byte),
        .out_data(fifo_data)
    );

    // Sequencer: a select fall opens the command byte, the token decides
    // when this device speaks, and the byte count decides when it stops.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else if (cs_idle) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state_reg <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (sclk_fall && bit_cnt_reg == LAST_BIT) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (start_xfer) begin
                        state_reg <= (len_reg == LEN_ZERO) ? ST_DONE : ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (sclk_rise && boundary_reg && bytes_left_reg == LEN_ZERO) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_DONE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Bit counter finds byte ends by counting falling edges from the
    // select fall; the boundary flag marks the rising edge of a new byte.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bit_cnt_reg <= FIRST_BIT;
            boundary_reg <= 1'b0;
        end else if (cs_idle || state_reg == ST_IDLE) begin
            bit_cnt_reg <= FIRST_BIT;
            boundary_reg <= 1'b0;
        end else if (sclk_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            boundary_reg <= (bit_cnt_reg == LAST_BIT);
        end else if (sclk_rise) begin
            boundary_reg <= 1'b0;
        end
    end

    // Input shifter; only the command byte and this device's own bytes
    // are taken, so waiting and finished devices ignore the line.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shift_in_reg <= BYTE_RESET;
            cmd_reg <= '0;
            rx_reg <= '0;
            len_reg <= LEN_ZERO;
        end else begin
            cmd_reg.valid <= 1'b0;
            rx_reg.valid <= 1'b0;
            if (sclk_fall && listening && !cs_idle) begin
                shift_in_reg <= {shift_in_reg[6:0], filt_next.din};
                if (bit_cnt_reg == LAST_BIT && state_reg == ST_CMD) begin
                    cmd_reg <= '{valid: 1'b1, data: {shift_in_reg[6:0], filt_next.din}};
                    len_reg <= reply_len;
                end
                if (bit_cnt_reg == LAST_BIT && state_reg == ST_XFER) begin
                    rx_reg <= '{valid: 1'b1, data: {shift_in_reg[6:0], filt_next.din}};
                end
            end
        end
    end

    // Remaining reply bytes, counted down as each byte completes.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bytes_left_reg <= LEN_ZERO;
        end else if (start_xfer) begin
            bytes_left_reg <= len_reg;
        end else if (sclk_fall && state_reg == ST_XFER && bit_cnt_reg == LAST_BIT
                     && bytes_left_reg != LEN_ZERO) begin
            bytes_left_reg <= bytes_left_reg - LEN_ONE;
        end
    end

    // Output shifter moves only on rising edges of the serial clock.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shift_out_reg <= BYTE_RESET;
            dout_reg <= 1'b0;
        end else if (load_byte) begin
            dout_reg <= next_byte[7];
            shift_out_reg <= {next_byte[6:0], 1'b0};
        end else if (sclk_rise && state_reg == ST_XFER && !boundary_reg) begin
            dout_reg <= shift_out_reg[7];
            shift_out_reg <= {shift_out_reg[6:0], 1'b0};
        end
    end

    // Output driver: opened by a select fall with the token low, or by a
    // token fall under a low select; closed by select high or the end.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dout_oe_reg <= 1'b0;
        end else if (cs_idle) begin
            dout_oe_reg <= 1'b0;
        end else if (cs_fall && !filt_next.token_n) begin
            dout_oe_reg <= 1'b1;
        end else if (start_xfer) begin
            dout_oe_reg <= (len_reg != LEN_ZERO);
        end else if (token_fall && state_reg != ST_IDLE && state_reg != ST_DONE) begin
            dout_oe_reg <= 1'b1;
        end else if (sclk_rise && boundary_reg && state_reg == ST_XFER
                     && bytes_left_reg == LEN_ZERO) begin
            dout_oe_reg <= 1'b0;
        end
    end

    // Token output falls after the rising edge that opens the last bit of
    // the last byte and stays low until the select rises.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            token_out_reg <= 1'b1;
        end else if (cs_idle) begin
            token_out_reg <= 1'b1;
        end else if (sclk_rise && state_reg == ST_XFER && bit_cnt_reg == LAST_BIT
                     && bytes_left_reg == LEN_ONE) begin
            token_out_reg <= 1'b0;
        end else if (start_xfer && len_reg == LEN_ZERO) begin
            token_out_reg <= 1'b0;
        end
    end

    // Ready chain: forced high by a high input, low on a new result, high
    // again at the next select fall; a result in that cycle wins.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ready_out_reg <= 1'b1;
        end else if (filt_next.rdy_in_n) begin
            ready_out_reg <= 1'b1;
        end else if (new_result) begin
            ready_out_reg <= 1'b0;
        end else if (cs_fall) begin
            ready_out_reg <= 1'b1;
        end
    end

    // Status pins pull low only; the board pull-up makes the wired-NOR.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_oe_reg <= 1'b0;
            over_oe_reg <= 1'b0;
        end else begin
            fault_oe_reg <= |chan_fault;
            over_oe_reg <= (|chan_overrange) || (|chan_fault);
        end
    end

    // Oscillator copy; sampling through flops costs up to one mclk of
    // jitter, traded for keeping every output on a flop.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            osc_sync_reg <= 3'h0;
            osc_out_reg <= 1'b0;
            osc_oe_reg <= 1'b0;
        end else begin
            osc_sync_reg <= {osc_sync_reg[1:0], crystal_in};
            if (osc_sync_reg[1] == osc_sync_reg[2]) begin
                osc_out_reg <= osc_sync_reg[2];
            end
            osc_oe_reg <= crystal_enable_bit && crystal_present;
        end
    end

    // Pin and user outputs.
    assign dout = dout_reg;
    assign dout_oe = dout_oe_reg;
    assign chain_token_out = token_out_reg;
    assign ready_chain_out = ready_out_reg;
    assign fault_n_o = 1'b0;
    assign fault_n_oe = fault_oe_reg;
    assign range_exceed_flag_n_o = 1'b0;
    assign range_exceed_flag_n_oe = over_oe_reg;
    assign buffered_osc_out = osc_out_reg;
    assign buffered_osc_out_oe = osc_oe_reg;
    assign cmd_out = cmd_reg;
    assign rx_out = rx_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_IDLE_HIZ: assert property (filt_reg.cs_n |-> !dout_oe_reg)
        else $error("Output driven while select is high.");
    AST_RX_ON_FALL: assert property (rx_reg.valid |-> $past(sclk_fall))
        else $error("Byte taken without a falling clock edge.");
    AST_DOUT_ON_RISE: assert property ($changed(dout_reg) |-> $past(sclk_rise))
        else $error("Output bit changed away from a rising edge.");
    AST_TOKEN_AFTER_RISE: assert property ($fell(token_out_reg) |-> $past(sclk_rise))
        else $error("Token output fell without a rising edge.");
    AST_XFER_NEEDS_TOKEN: assert property (
        state_reg == ST_WAIT ##1 state_reg == ST_XFER |-> $past(!filt_next.token_n && sclk_rise))
        else $error("Transfer opened without a low token at a rising edge.");
    AST_DONE_QUIET: assert property (state_reg == ST_DONE |-> !dout_oe_reg && !rx_reg.valid)
        else $error("Finished device still drives or takes data.");
    AST_CS_FALL_OPENS: assert property (cs_fall && !filt_next.token_n |=> dout_oe_reg)
        else $error("Select fall with low token left output off.");
    AST_FAULT_PIN: assert property (|chan_fault |=> fault_n_oe && range_exceed_flag_n_oe)
        else $error("Fault not shown on both open-drain pins.");
    AST_OVER_PIN: assert property (
        $rose(|chan_overrange) && !(|chan_fault) |=> range_exceed_flag_n_oe ##1 1'b1)
        else $error("Overrange not shown on overflow pin.");
    AST_CLK_OFF: assert property (!crystal_enable_bit |=> !buffered_osc_out_oe)
        else $error("Clock output driven with its enable bit clear.");
    AST_READY_HIGH: assert property (filt_reg.rdy_in_n |-> ready_chain_out)
        else $error("Ready chain output low while its input is high.");
    AST_LAST_BIT_RX: assert property (rx_reg.valid |-> boundary_reg && bit_cnt_reg == FIRST_BIT)
        else $error("Byte completed away from an eight-bit boundary.");

    COV_XFER: cover property (state_reg == ST_WAIT ##1 state_reg == ST_XFER);
    COV_DONE: cover property (state_reg == ST_XFER ##1 state_reg == ST_DONE);
    COV_TOKEN: cover property ($fell(token_out_reg));
    COV_RX: cover property (rx_reg.valid);

endmodule

// File: spi_host_model.sv
module spi_host_model (
    // Serial link pins.
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic last_bit = 1'b0;

    // Idle levels; the clock rests high between frames.
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // Select moves only while the clock rests high, then settles.
    task automatic select(input logic lvl);
        cs_n <= lvl;
        #125;
    endtask

    // One byte MSB first; both sides sample at the fall.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            din <= tx[i];
            #31;
            // A released line shows the inverse of its last level, so it never matches by luck.
            last_bit = dout_oe ? dout : ~last_bit;
            rx[i] = last_bit;
            sclk <= 1'b0;
            #62.5;
            sclk <= 1'b1;
            #31.5;
        end
    endtask
endmodule

// File: testbench.sv
module testbench
    import cascade_serial_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk, rst, sclk, cs_n, din, dout, dout_oe;
    logic chain_token_in, chain_token_out, ready_chain_in, ready_chain_out;
    logic fault_n_o, fault_n_oe, range_exceed_flag_n_o, range_exceed_flag_n_oe;
    logic crystal_in = 1'b0;
    logic crystal_present, crystal_enable_bit;
    logic buffered_osc_out, buffered_osc_out_oe, new_result, tx_valid, tx_ready;
    logic [3:0] chan_fault, chan_overrange;
    logic [1:0] osc_cnt = 2'h0;
    logic [7:0] tx_data, got;
    logic [LEN_W-1:0] reply_len;
    byte_evt_t cmd_out, rx_out;
    logic [7:0] cmd_q[$], rx_q[$];
    int err_count = 0;
    int num_checks = 0;

    cascade_serial_port i_cascade_serial_port (.mclk(mclk), .rst(rst), .sclk(sclk),
        .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
        .chain_token_in(chain_token_in), .chain_token_out(chain_token_out),
        .ready_chain_in(ready_chain_in), .ready_chain_out(ready_chain_out),
        .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
        .range_exceed_flag_n_o(range_exceed_flag_n_o),
        .range_exceed_flag_n_oe(range_exceed_flag_n_oe), .crystal_in(crystal_in),
        .crystal_present(crystal_present), .crystal_enable_bit(crystal_enable_bit),
        .buffered_osc_out(buffered_osc_out), .buffered_osc_out_oe(buffered_osc_out_oe),
        .chan_fault(chan_fault), .chan_overrange(chan_overrange), .new_result(new_result),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .reply_len(reply_len), .cmd_out(cmd_out), .rx_out(rx_out));

    spi_host_model i_spi_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe));

    // System clock, 100 MHz.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Oscillator stand-in, 80 ns period, slow enough for the pin filter.
    always @(posedge mclk) begin
        osc_cnt <= osc_cnt + 2'h1;
        if (osc_cnt == 2'h3) begin
            crystal_in <= ~crystal_in;
        end
    end

    // Byte strobes last one cycle, so they are queued as they pass.
    always @(posedge mclk) begin
        if (cmd_out.valid === 1'b1) begin
            cmd_q.push_back(cmd_out.data);
        end
        if (rx_out.valid === 1'b1) begin
            rx_q.push_back(rx_out.data);
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t ns: %s got %h want %h", $time, m, g, e);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic give_verdict;
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Full buffer, own four-byte reply, then the device must fall silent.
    task automatic test_transfer;
        logic [7:0] exp[4] = '{8'ha5, 8'h3c, 8'h0f, 8'h96};
        tx_valid <= 1'b1;
        foreach (exp[i]) begin
            tx_data <= exp[i];
            @(posedge mclk);
        end
        tx_valid <= 1'b0;
        reply_len <= 8'h04;
        chain_token_in <= 1'b0;
        wait_clk(2);
        chk(8'(tx_ready), 8'h00, "full buffer");
        i_spi_host_model.select(1'b0);
        chk(8'(dout_oe), 8'h01, "driver on");
        i_spi_host_model.xfer(8'hc1, got);
        for (int i = 0; i < 4; i++) begin
            i_spi_host_model.xfer(8'h10 + 8'(i), got);
            chk(got, exp[i], "reply byte");
        end
        wait_clk(8);
        chk(8'(chain_token_out), 8'h00, "token passed");
        chk(8'(dout_oe), 8'h00, "driver off");
        i_spi_host_model.xfer(8'h77, got);
        chk(8'(rx_q.size()), 8'h04, "rx count");
        chk(cmd_q.pop_front(), 8'hc1, "command");
        for (int i = 0; i < 4; i++) begin
            chk(rx_q.pop_front(), 8'h10 + 8'(i), "rx byte");
        end
        i_spi_host_model.select(1'b1);
        chk(8'(chain_token_out), 8'h01, "token back");
        chk(8'(tx_ready), 8'h01, "buffer drained");
        $display("test_transfer done");
    endtask

    // Token high at select: wait, then a late token fall enables the driver.
    task automatic test_token_wait;
        cmd_q.delete();
        reply_len <= 8'h01;
        chain_token_in <= 1'b1;
        wait_clk(2);
        i_spi_host_model.select(1'b0);
        chk(8'(dout_oe), 8'h00, "no driver");
        i_spi_host_model.xfer(8'h5a, got);
        i_spi_host_model.xfer(8'h33, got);
        chk(8'(rx_q.size()), 8'h00, "waiting");
        @(posedge mclk);
        chain_token_in <= 1'b0;
        wait_clk(6);
        chk(8'(dout_oe), 8'h01, "late driver");
        // Byte already open when the token fell is not taken.
        i_spi_host_model.xfer(8'h44, got);
        i_spi_host_model.xfer(8'he7, got);
        chk(got, 8'h00, "empty reply");
        chk(8'(rx_q.size()), 8'h01, "one rx");
        chk(rx_q.pop_front(), 8'he7, "rx byte");
        chk(cmd_q.pop_front(), 8'h5a, "command");
        i_spi_host_model.select(1'b1);
        chk(8'(dout_oe), 8'h00, "deselected");
        $display("test_token_wait done");
    endtask

    // Clocking with select high must be ignored.
    task automatic test_deselected;
        i_spi_host_model.xfer(8'hff, got);
        wait_clk(4);
        chk(8'(cmd_q.size()), 8'h00, "no command");
        chk(8'(dout_oe), 8'h00, "no driver");
        $display("test_deselected done");
    endtask

    // Fault, overflow, oscillator and ready chain pins.
    task automatic test_status;
        chan_fault <= 4'h2;
        wait_clk(6);
        chk(8'({fault_n_oe, fault_n_o, range_exceed_flag_n_oe}), 8'h05, "fault");
        chan_fault <= 4'h0;
        chan_overrange <= 4'h8;
        wait_clk(6);
        chk(8'({fault_n_oe, range_exceed_flag_n_oe, range_exceed_flag_n_o}), 8'h02,
            "overrange");
        chan_overrange <= 4'h0;
        crystal_present <= 1'b0;
        crystal_enable_bit <= 1'b1;
        wait_clk(6);
        chk(8'(buffered_osc_out_oe), 8'h00, "no crystal");
        crystal_present <= 1'b1;
        wait_clk(8);
        got[0] = buffered_osc_out;
        wait_clk(4);
        chk(8'({buffered_osc_out_oe, buffered_osc_out}), {6'h0, 1'b1, ~got[0]},
            "osc on");
        crystal_enable_bit <= 1'b0;
        ready_chain_in <= 1'b0;
        wait_clk(6);
        chk(8'(buffered_osc_out_oe), 8'h00, "osc off");
        new_result <= 1'b1;
        @(posedge mclk);
        new_result <= 1'b0;
        wait_clk(3);
        chk(8'(ready_chain_out), 8'h00, "ready low");
        i_spi_host_model.select(1'b0);
        chk(8'(ready_chain_out), 8'h01, "ready cleared");
        i_spi_host_model.select(1'b1);
        @(posedge mclk);
        new_result <= 1'b1;
        @(posedge mclk);
        new_result <= 1'b0;
        wait_clk(3);
        chk(8'(ready_chain_out), 8'h00, "ready low again");
        ready_chain_in <= 1'b1;
        wait_clk(6);
        chk(8'(ready_chain_out), 8'h01, "ready held");
        $display("test_status done");
    endtask

    // Main sequence.
    initial begin
        rst = 1'b1;
        chain_token_in = 1'b1;
        ready_chain_in = 1'b1;
        crystal_present = 1'b1;
        crystal_enable_bit = 1'b0;
        chan_fault = 4'h0;
        chan_overrange = 4'h0;
        new_result = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        reply_len = 8'h00;
        wait_clk(20);
        rst <= 1'b0;
        wait_clk(2);
        test_transfer();
        test_token_wait();
        test_deselected();
        test_status();
        give_verdict();
    end

    // Watchdog, far beyond the roughly 13 microseconds the tests need.
    initial begin
        #200000;
        err_count++;
        $display("ERROR %0t ns: watchdog expired", $time);
        give_verdict();
    end
endmodule
